// [core/pot_spi_pkg.sv]
// Constants, types and frame layout for the potentiometer serial command decoder.
// Assumes a single 250 MHz system clock; all pins arrive asynchronously.
// How it works
// - First byte after select falls is identification.
// - Upper four identification bits must match type.
// - Address bits must match address pins.
// - Type, zero, address high, low, direction bit.
// - Instruction byte: opcode, two select bits, fixed.
// - 0x80 read wiper, 0xA0 write wiper.
// - 1010ss00 read setting, 1100ss00 write setting.
// - 1100ss00 read-dir loads wiper, 1110ss00 stores wiper.
// - 0x41 with read direction reads status.
// - Data instructions are four bytes per select.
// - Value: six pad bits, bits 9..8, 7..0.
// - Status: pad byte, seven zeros, then busy.
// - Copy instructions are two bytes only.
// - Wiper output follows after settle delay.
// - Setting store lasts the write cycle time.
// - Store starts on select rise after complete frame.
// - Busy flag readable while store runs.
// - Four ten-bit setting registers, bit 9 MSB.
// - Status register is one bit wide.
// - Sample input on rising, shift output falling.
// - Pause input changes only while clock low.
// - Write-protect low blocks setting stores.
// - Busy reads 1 during store, else 0.

package pot_spi_pkg;

   localparam int CLK_PERIOD_NS = 4;
   localparam int WIPER_SETTLE_NS = 10000;
   localparam int NV_WRITE_NS = 10000000;
   localparam logic [11:0] SETTLE_CYCLES = 12'(WIPER_SETTLE_NS / CLK_PERIOD_NS);
   localparam int NV_WRITE_CYCLES_DEF = (NV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam logic [5:0] BITS_ID = 6'h08;
   localparam logic [5:0] BITS_INSTR = 6'h10;
   localparam logic [5:0] BITS_DATA = 6'h20;

   localparam int ID_ZERO_POS = 3;
   localparam int ID_ADDR_HI_POS = 2;
   localparam int ID_ADDR_LO_POS = 1;
   localparam int ID_DIR_POS = 0;

   localparam logic [7:0] INS_RD_WIPER = 8'h80;
   localparam logic [7:0] INS_WR_WIPER = 8'hA0;
   localparam logic [7:0] INS_STATUS = 8'h41;
   localparam logic [3:0] OPC_RD_SET = 4'hA;
   localparam logic [3:0] OPC_WR_SET = 4'hC;
   localparam logic [3:0] OPC_SET_TO_WIPER = 4'hC;
   localparam logic [3:0] OPC_WIPER_TO_SET = 4'hE;
   localparam logic [1:0] INS_TAIL = 2'h0;

   localparam logic [5:0] DATA_PAD = 6'h00;
   localparam logic [14:0] STATUS_PAD = 15'h0000;
   localparam logic [9:0] WIPER_RESET = 10'h000;
   localparam logic [9:0] SETTING_RESET = 10'h000;

   typedef enum logic [2:0] {ST_ID, ST_INSTR, ST_DATA, ST_DONE, ST_IGNORE} frame_state_e;
   typedef enum logic [2:0] {
      OP_NONE, OP_RD_WIPER, OP_WR_WIPER, OP_RD_SET, OP_WR_SET,
      OP_SET_TO_WIPER, OP_WIPER_TO_SET, OP_RD_STATUS
   } op_e;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
      logic hold_n;
      logic wp_n;
      logic addr_hi;
      logic addr_lo;
   } pin_in_s;

   localparam pin_in_s PIN_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1,
                                    wp_n: 1'b1, addr_hi: 1'b0, addr_lo: 1'b0};

endpackage : pot_spi_pkg

// [core/pot_spi_command_decoder.sv]
// Serial command decoder of a digital potentiometer: frame decode, wiper,
// four setting registers, busy flag. Pins are asynchronous to sys_clk and
// the serial clock must be slow enough to be oversampled (80 ns or more).
`timescale 1ns/1ps
`default_nettype none

module pot_spi_command_decoder
   import pot_spi_pkg::*;
#(
   parameter int NV_WRITE_CYCLES = NV_WRITE_CYCLES_DEF,
   // Arbitrary type code
   parameter logic [3:0] TYPE_CODE = 4'hA
)(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic hold_n,
   input wire logic wp_n,
   input wire logic addr_pin_hi,
   input wire logic addr_pin_lo,
   output var logic so_out,
   output var logic so_oe,
   output var logic [9:0] wiper_tap,
   output var logic wip
);

   localparam int NV_W = $clog2(NV_WRITE_CYCLES + 1);
   localparam logic [NV_W-1:0] NV_LOAD = NV_W'(NV_WRITE_CYCLES);
   localparam logic [NV_W-1:0] NV_ONE = NV_W'(1);

   generate
      // The busy-duration check below (chk_wip_duration) needs at least eight busy cycles
      if (NV_WRITE_CYCLES < 8)
      begin : g_bad_nv
         $error("NV_WRITE_CYCLES must be at least 8");
      end
   endgenerate

   pin_in_s pin_raw;
   pin_in_s pin_meta;
   pin_in_s pin_s;
   logic sck_prev;
   logic cs_prev;
   logic paused;
   frame_state_e state;
   op_e op;
   op_e next_op;
   logic [5:0] bit_cnt;
   logic [15:0] rx_shift;
   logic [15:0] tx_shift;
   logic dir_read;
   logic [1:0] sel;
   logic [9:0] wr_data;
   logic [9:0] wiper_position_reg;
   logic [9:0] stored_setting_reg [4];
   logic [11:0] settle_cnt;
   logic [NV_W-1:0] nv_cnt;
   logic [1:0] nv_sel;
   logic [9:0] nv_data;

   assign pin_raw = {cs_n, sck, si, hold_n, wp_n, addr_pin_hi, addr_pin_lo};

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_meta <= PIN_IDLE;
         pin_s <= PIN_IDLE;
         sck_prev <= 1'b0;
         cs_prev <= 1'b1;
      end
      else
      begin
         pin_meta <= pin_raw;
         pin_s <= pin_meta;
         sck_prev <= pin_s.sck;
         cs_prev <= pin_s.cs_n;
      end
   end

   wire sck_rise = pin_s.sck & ~sck_prev;
   wire sck_fall = ~pin_s.sck & sck_prev;
   wire cs_rise = pin_s.cs_n & ~cs_prev;
   wire active = ~pin_s.cs_n & ~paused;
   wire shift_en = active & sck_rise;
   wire [15:0] next_shift = {rx_shift[14:0], pin_s.si};
   wire [5:0] next_bits = bit_cnt + 6'h01;
   wire [7:0] rx_byte = next_shift[7:0];

   // Pause only recognised with the serial clock low
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         paused <= 1'b0;
      else if (!pin_s.sck)
         paused <= ~pin_s.hold_n;
   end

   wire type_ok = (rx_byte[7:4] == TYPE_CODE) && !rx_byte[ID_ZERO_POS];
   wire addr_ok = (rx_byte[ID_ADDR_HI_POS] == pin_s.addr_hi)
                  && (rx_byte[ID_ADDR_LO_POS] == pin_s.addr_lo);
   wire id_done = shift_en && state == ST_ID && next_bits == BITS_ID;
   wire instr_done = shift_en && state == ST_INSTR && next_bits == BITS_INSTR;
   wire data_done = shift_en && state == ST_DATA && next_bits == BITS_DATA;
   wire tail_ok = rx_byte[1:0] == INS_TAIL;
   wire two_byte = next_op == OP_SET_TO_WIPER || next_op == OP_WIPER_TO_SET;

   always_comb
   begin
      next_op = OP_NONE;
      if (dir_read && rx_byte == INS_RD_WIPER)
         next_op = OP_RD_WIPER;
      else if (!dir_read && rx_byte == INS_WR_WIPER)
         next_op = OP_WR_WIPER;
      else if (dir_read && rx_byte == INS_STATUS)
         next_op = OP_RD_STATUS;
      else if (tail_ok && dir_read && rx_byte[7:4] == OPC_RD_SET)
         next_op = OP_RD_SET;
      else if (tail_ok && !dir_read && rx_byte[7:4] == OPC_WR_SET)
         next_op = OP_WR_SET;
      else if (tail_ok && dir_read && rx_byte[7:4] == OPC_SET_TO_WIPER)
         next_op = OP_SET_TO_WIPER;
      else if (tail_ok && !dir_read && rx_byte[7:4] == OPC_WIPER_TO_SET)
         next_op = OP_WIPER_TO_SET;
   end

   // Frame sequencer; deselect restarts it from the identification byte
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= ST_ID;
         bit_cnt <= 6'h00;
         rx_shift <= 16'h0000;
         dir_read <= 1'b0;
         op <= OP_NONE;
         sel <= 2'h0;
         wr_data <= WIPER_RESET;
      end
      else if (pin_s.cs_n)
      begin
         state <= ST_ID;
         bit_cnt <= 6'h00;
      end
      else if (shift_en && state != ST_DONE && state != ST_IGNORE)
      begin
         rx_shift <= next_shift;
         bit_cnt <= next_bits;
         if (id_done)
         begin
            dir_read <= rx_byte[ID_DIR_POS];
            state <= (type_ok && addr_ok) ? ST_INSTR : ST_IGNORE;
         end
         else if (instr_done)
         begin
            op <= next_op;
            sel <= rx_byte[3:2];
            if (next_op == OP_NONE)
               state <= ST_IGNORE;
            else
               state <= two_byte ? ST_DONE : ST_DATA;
         end
         else if (data_done)
         begin
            wr_data <= next_shift[9:0];
            state <= ST_DONE;
         end
      end
   end

   wire op_reads = op == OP_RD_WIPER || op == OP_RD_SET || op == OP_RD_STATUS;
   wire [15:0] next_tx = (next_op == OP_RD_STATUS) ? {STATUS_PAD, wip}
                       : (next_op == OP_RD_WIPER) ? {DATA_PAD, wiper_position_reg}
                       : {DATA_PAD, stored_setting_reg[rx_byte[3:2]]};
   wire drive_fall = active && sck_fall && state == ST_DATA && op_reads;
   // After a pause the bit already shifted out shows again before the next rise, except the first data bit (bit_cnt at BITS_INSTR)
   wire oe_resume = active && state == ST_DATA && op_reads && bit_cnt != BITS_INSTR;

   // Read data leaves on falling edges so it is stable for the host's rising edge
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_shift <= 16'h0000;
         so_out <= 1'b0;
         so_oe <= 1'b0;
      end
      else
      begin
         if (instr_done)
            tx_shift <= next_tx;
         else if (drive_fall)
            tx_shift <= {tx_shift[14:0], 1'b0};
         if (drive_fall)
            so_out <= tx_shift[15];
         if (pin_s.cs_n || paused)
            so_oe <= 1'b0;
         else if (drive_fall || oe_resume)
            so_oe <= 1'b1;
      end
   end

   // Commands act when select rises after a complete frame
   wire commit = cs_rise && state == ST_DONE;
   wire wiper_load = commit && (op == OP_WR_WIPER || op == OP_SET_TO_WIPER);
   wire nv_req = commit && (op == OP_WR_SET || op == OP_WIPER_TO_SET);
   wire nv_start = nv_req && pin_s.wp_n && !wip;
   wire nv_finish = wip && nv_cnt == NV_ONE;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wiper_position_reg <= WIPER_RESET;
         wiper_tap <= WIPER_RESET;
         settle_cnt <= 12'h000;
      end
      else
      begin
         if (wiper_load)
         begin
            wiper_position_reg <= (op == OP_WR_WIPER) ? wr_data : stored_setting_reg[sel];
            settle_cnt <= SETTLE_CYCLES;
         end
         else if (settle_cnt != 12'h000)
            settle_cnt <= settle_cnt - 12'h001;
         if (settle_cnt == 12'h001 && !wiper_load)
            wiper_tap <= wiper_position_reg;
      end
   end

   // Busy flag covers the whole store; a store asked for while busy is dropped
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wip <= 1'b0;
         nv_cnt <= '0;
         nv_sel <= 2'h0;
         nv_data <= SETTING_RESET;
      end
      else if (nv_start)
      begin
         wip <= 1'b1;
         nv_cnt <= NV_LOAD;
         nv_sel <= sel;
         nv_data <= (op == OP_WR_SET) ? wr_data : wiper_position_reg;
      end
      else if (wip)
      begin
         nv_cnt <= nv_cnt - NV_ONE;
         if (nv_cnt == NV_ONE)
            wip <= 1'b0;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_setting
         always_ff @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
               stored_setting_reg[g] <= SETTING_RESET;
            else if (nv_finish && nv_sel == 2'(g))
               stored_setting_reg[g] <= nv_data;
         end
      end
   endgenerate

   // Helper counters time the busy and settle periods apart from the
   // control counters, so a miscounted control counter shows up
   logic [NV_W-1:0] busy_len;
   logic [11:0] since_load;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         busy_len <= '0;
      else if (wip)
         busy_len <= busy_len + NV_ONE;
      else
         busy_len <= '0;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         since_load <= 12'h000;
      else if (wiper_load)
         since_load <= 12'h001;
      else if (since_load != 12'h000 && since_load != SETTLE_CYCLES + 12'h001)
         since_load <= since_load + 12'h001;
   end

   // Frame, output and timing checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   chk_oe_needs_select: assert property (pin_s.cs_n |=> !so_oe)
      else $error("SO driven while deselected");
   chk_oe_read_only: assert property (so_oe |-> op_reads)
      else $error("SO driven outside read");
   chk_type_mismatch: assert property (id_done && !type_ok |=> state == ST_IGNORE)
      else $error("Wrong type code accepted");
   chk_addr_mismatch: assert property (id_done && !addr_ok |=> state == ST_IGNORE)
      else $error("Wrong address accepted");
   chk_store_on_rise: assert property (nv_start |-> cs_rise
                                       && (bit_cnt == BITS_DATA
                                       || (op == OP_WIPER_TO_SET && bit_cnt == BITS_INSTR)))
      else $error("Store started without complete frame");
   chk_protect_blocks: assert property (nv_req && !pin_s.wp_n && !wip |=> !wip)
      else $error("Store ran while protected");
   chk_wip_length: assert property ($fell(wip) |-> busy_len == NV_LOAD)
      else $error("Busy period length wrong");
   chk_settle_exact: assert property (wiper_tap != $past(wiper_tap)
                                      |-> since_load == SETTLE_CYCLES + 12'h001)
      else $error("Wiper moved at wrong time");
   chk_status_busy: assert property (instr_done && next_op == OP_RD_STATUS
                                     |=> tx_shift[0] == $past(wip))
      else $error("Status bit not the busy flag");
   chk_pause_holds: assert property (paused && !pin_s.cs_n && sck_rise
                                     |=> $stable(bit_cnt) && $stable(rx_shift))
      else $error("Clock taken while paused");
   chk_wip_duration: assert property (nv_start |=> wip [*8])
      else $error("Busy flag dropped early");
   chk_wip_on_start: assert property (nv_start |=> wip && nv_cnt == NV_LOAD)
      else $error("Busy flag not raised");
   chk_settle_delay: assert property (wiper_load |=> wiper_tap == $past(wiper_tap) [*8])
      else $error("Wiper moved before settle delay");
   chk_status_word: assert property (instr_done && next_op == OP_RD_STATUS
                                     |=> tx_shift[15:1] == STATUS_PAD)
      else $error("Status word padding wrong");
   chk_two_byte: assert property (instr_done && two_byte |=> state == ST_DONE)
      else $error("Copy instruction expects data");

endmodule : pot_spi_command_decoder

`default_nettype wire

// [tb/pot_spi_host_model.sv]
// Serial host model for the potentiometer command decoder.
// Assumes sys_clk at 250 MHz; serial clock made at 80 ns from it.
`timescale 1ns/1ps
`default_nettype none

module pot_spi_host_model
   import pot_spi_pkg::*;
(
   input wire logic sys_clk,
   input wire logic so_out,
   input wire logic so_oe,
   output logic cs_n,
   output logic sck,
   output logic si,
   output logic hold_n
);
   initial
   begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      hold_n = 1'b1;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : wt

   // Sends bits 31 down to 32-n; pz picks a bit that is paused before
   task automatic xfer(input logic [31:0] tx, input int n, input int pz,
                       output logic [31:0] rx);
      rx = 'z;
      @(posedge sys_clk);
      cs_n <= 1'b0;
      for (int i = 31; i >= 32 - n; i--)
      begin
         wt(5);
         si <= tx[i];
         if (i == pz)
         begin
            // A clock pulse inside the pause must be ignored
            hold_n <= 1'b0;
            wt(5);
            sck <= 1'b1;
            wt(5);
            sck <= 1'b0;
            wt(5);
            hold_n <= 1'b1;
            wt(5);
         end
         wt(5);
         // Sampled late in the low phase, device shifts on the fall
         rx[i] = so_oe ? so_out : 1'bz;
         sck <= 1'b1;
         wt(10);
         sck <= 1'b0;
      end
      wt(10);
      cs_n <= 1'b1;
      // Released line shows no stale value
      si <= ~si;
      wt(5);
   endtask : xfer
endmodule : pot_spi_host_model
`default_nettype wire

// [tb/pot_spi_command_decoder_tb_top.sv]
// Testbench for the potentiometer command decoder.
// Assumes the host model in tb/ and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none

module pot_spi_command_decoder_tb_top;
   import pot_spi_pkg::*;
   localparam int NVW = 1000;
   localparam logic [3:0] TC = 4'hA;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic wp_n = 1'b1;
   logic addr_pin_hi = 1'b1;
   logic addr_pin_lo = 1'b0;
   logic cs_n, sck, si, hold_n, so_out, so_oe, wip;
   logic [9:0] wiper_tap;
   logic [31:0] rx;
   int err_count = 0;
   int tests_run = 0;

   always #2 sys_clk = ~sys_clk;

   pot_spi_command_decoder #(.NV_WRITE_CYCLES(NVW), .TYPE_CODE(TC)) DUT (
      .sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si),
      .hold_n(hold_n), .wp_n(wp_n), .addr_pin_hi(addr_pin_hi),
      .addr_pin_lo(addr_pin_lo), .so_out(so_out), .so_oe(so_oe),
      .wiper_tap(wiper_tap), .wip(wip));

   pot_spi_host_model host (.sys_clk(sys_clk), .so_out(so_out), .so_oe(so_oe),
      .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));

   task automatic wrap_up();
      $display("Counts: tests_run=%0d err_count=%0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [7:0] idb(input logic dir);
      return {TC, 1'b0, 2'b10, dir};
   endfunction : idb

   task automatic frm(input logic [7:0] id, input logic [7:0] ins, input logic [9:0] d,
                      input int n, input int pz);
      host.xfer({id, ins, DATA_PAD, d}, n, pz, rx);
   endtask : frm

   task automatic wait_idle();
      int k;
      for (k = 0; k < NVW + 50 && wip === 1'b1; k++)
         @(posedge sys_clk);
      if (k >= NVW + 50)
      begin
         err_count++;
         $display("Error t=%0t busy stuck got=%h exp=%h", $time, wip, 1'b0);
         wrap_up();
      end
   endtask : wait_idle

   task automatic t_wiper();
      frm(idb(0), INS_WR_WIPER, 10'h2A5, 32, 27);
      chk(rx, 'z);
      host.wt(100);
      chk(wiper_tap, 32'h0);
      host.wt(2450);
      chk(wiper_tap, 32'h2A5);
      frm(idb(1), INS_RD_WIPER, 10'h000, 32, 10);
      chk(rx, {16'hzzzz, 16'h02A5});
      $display("t_wiper done");
   endtask : t_wiper

   task automatic t_setting();
      for (int s = 0; s < 4; s++)
      begin
         frm(idb(0), {OPC_WR_SET, 2'(s), 2'b00}, {2'(s), 8'h5A}, 32, -1);
         chk(wip, 32'h1);
         if (s == 0)
         begin
            frm(idb(1), INS_STATUS, 10'h000, 32, -1);
            chk(rx, {16'hzzzz, 16'h0001});
         end
         wait_idle();
      end
      frm(idb(1), INS_STATUS, 10'h000, 32, -1);
      chk(rx, {16'hzzzz, 16'h0000});
      for (int s = 0; s < 4; s++)
      begin
         frm(idb(1), {OPC_RD_SET, 2'(s), 2'b00}, 10'h000, 32, -1);
         chk(rx, {16'hzzzz, 6'h00, 2'(s), 8'h5A});
      end
      $display("t_setting done");
   endtask : t_setting

   task automatic t_copy();
      frm(idb(0), INS_WR_WIPER, 10'h155, 32, -1);
      frm(idb(0), {OPC_WIPER_TO_SET, 2'd2, 2'b00}, 10'h000, 16, -1);
      chk(wip, 32'h1);
      wait_idle();
      frm(idb(1), {OPC_RD_SET, 2'd2, 2'b00}, 10'h000, 32, -1);
      chk(rx, {16'hzzzz, 16'h0155});
      frm(idb(1), {OPC_SET_TO_WIPER, 2'd1, 2'b00}, 10'h000, 16, -1);
      host.wt(2600);
      chk(wiper_tap, 32'h15A);
      $display("t_copy done");
   endtask : t_copy

   task automatic t_refuse();
      frm(idb(1) ^ 8'h10, INS_RD_WIPER, 10'h000, 32, -1);
      chk(rx, 'z);
      frm(idb(0) ^ 8'h06, {OPC_WR_SET, 4'h0}, 10'h3FF, 32, -1);
      chk(wip, 32'h0);
      frm(idb(0), {OPC_WR_SET, 4'h0}, 10'h3FF, 24, -1);
      chk(wip, 32'h0);
      frm(idb(0), {OPC_WR_SET, 4'h1}, 10'h3FF, 32, -1);
      chk(wip, 32'h0);
      @(posedge sys_clk);
      wp_n <= 1'b0;
      frm(idb(0), {OPC_WR_SET, 4'h0}, 10'h3FF, 32, -1);
      chk(wip, 32'h0);
      wp_n <= 1'b1;
      frm(idb(1), {OPC_RD_SET, 4'h0}, 10'h000, 32, -1);
      chk(rx, {16'hzzzz, 16'h005A});
      $display("t_refuse done");
   endtask : t_refuse

   initial
   begin
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      host.wt(4);
      t_wiper();
      t_setting();
      t_copy();
      t_refuse();
      wrap_up();
   end
endmodule : pot_spi_command_decoder_tb_top
`default_nettype wire
